// File: rtl/vdc_pkg.sv
package vdc_pkg;

  // ==========================================================
  // Level code and decoder
  // ==========================================================
  localparam int unsigned CODE_W      = 7;
  localparam int unsigned UV_W        = 22;
  localparam logic [6:0]  LEVEL_RST   = 7'h32;
  localparam int unsigned PAR_BIT     = 7;
  localparam int unsigned IGNORED_BIT = 5;
  localparam int unsigned BASE_UV     = 700000;
  localparam int unsigned STEP_UV     = 7290;
  localparam int unsigned SPAN_MAX_UV = 1159270;

  // ==========================================================
  // Serial address byte
  // ==========================================================
  localparam logic [4:0] ADDR_PREFIX = 5'h0d;
  localparam logic       UPPER_SEL   = 1'b0;
  localparam logic       ADDR_LSB    = 1'b0;

  // ==========================================================
  // Start-up timing
  // ==========================================================
  localparam int unsigned CLK_HZ       = 20000000;
  localparam int unsigned SS_TIME_US   = 4000;
  localparam int unsigned SS_CYC       = SS_TIME_US * (CLK_HZ / 1000000);
  localparam int unsigned SS_CNT_W     = 17;
  localparam int unsigned RAMP_STEP_UV = 15;
  localparam int unsigned RAMP_MAX_UV  = 1200000;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum {ST_OFF, ST_RAMP, ST_RUN} vdc_state_e;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } vdc_wr_s;

  typedef struct packed {
    logic ack;
    logic nack;
  } vdc_wr_ans_s;

endpackage : vdc_pkg

// File: rtl/vdc_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

module vdc_ctrl #(
  parameter int unsigned SS_CYCLES = vdc_pkg::SS_CYC
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     enable_i,
  input  wire logic                     supply_ok_i,
  input  wire logic                     input_present_i,
  input  wire logic                     address_select_pin_i,
  input  wire vdc_pkg::vdc_wr_s         level_wr_i,
  input  wire logic                     mode_wr_i,
  input  wire logic                     mode_data_i,
  input  wire logic [vdc_pkg::UV_W-1:0] initial_level_input_i,
  input  wire logic [vdc_pkg::UV_W-1:0] sense_uv_i,
  input  wire logic [vdc_pkg::UV_W-1:0] ripple_uv_i,
  output vdc_pkg::vdc_wr_ans_s          level_ans_o,
  output logic [7:0]                    level_reg_o,
  output logic                          mode_o,
  output logic [7:0]                    slave_addr_o,
  output logic [vdc_pkg::UV_W-1:0]      ref_uv_o,
  output logic                          ramp_active_o,
  output logic                          regulation_ok_output_o,
  output logic                          discharge_on_o,
  output logic                          enable_pulldown_o,
  output logic                          one_shot_fire_o
);

  // ==========================================================
  // Functions
  // ==========================================================
  function automatic logic parity_of(input logic [6:0] c);
    parity_of = ~^c;
  endfunction : parity_of

  function automatic logic [vdc_pkg::UV_W-1:0] decode_uv(input logic [6:0] c);
    logic [5:0]  idx;
    logic [31:0] uv;
    idx = {c[6], c[4:0]};
    uv  = vdc_pkg::BASE_UV + 32'(idx) * vdc_pkg::STEP_UV;
    if (uv > vdc_pkg::SPAN_MAX_UV) begin
      uv = vdc_pkg::SPAN_MAX_UV;
    end
    decode_uv = uv[vdc_pkg::UV_W-1:0];
  endfunction : decode_uv

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic       en_s;
  logic       sup_s;
  logic       vin_s;
  logic       sel_s;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_reg <= 4'h0;
    end else begin
      sync1_reg <= {enable_i, supply_ok_i, input_present_i, address_select_pin_i};
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync2_reg <= 4'h0;
    end else begin
      sync2_reg <= sync1_reg;
    end
  end

  assign en_s  = sync2_reg[3];
  assign sup_s = sync2_reg[2];
  assign vin_s = sync2_reg[1];
  assign sel_s = sync2_reg[0];

  // ==========================================================
  // Output level register and mode bit
  // ==========================================================
  logic [6:0] code_reg;
  logic       mode_reg;
  logic       par_ok;
  logic       wr_take;

  assign par_ok = level_wr_i.data[vdc_pkg::PAR_BIT] == parity_of(level_wr_i.data[6:0]);
  assign wr_take = level_wr_i.valid && par_ok;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      code_reg <= vdc_pkg::LEVEL_RST;
    end else if (wr_take) begin
      code_reg <= level_wr_i.data[6:0];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_reg <= 1'b0;
    end else if (mode_wr_i) begin
      mode_reg <= mode_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      level_ans_o <= '0;
    end else begin
      level_ans_o.ack  <= wr_take;
      level_ans_o.nack <= level_wr_i.valid && !par_ok;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      level_reg_o <= {parity_of(vdc_pkg::LEVEL_RST), vdc_pkg::LEVEL_RST};
    end else begin
      level_reg_o <= {parity_of(code_reg), code_reg};
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_o <= 1'b0;
    end else begin
      mode_o <= mode_reg;
    end
  end

  // ==========================================================
  // Address byte
  // ==========================================================
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      slave_addr_o <= {vdc_pkg::ADDR_PREFIX, vdc_pkg::UPPER_SEL, 1'b0, vdc_pkg::ADDR_LSB};
    end else begin
      slave_addr_o <= {vdc_pkg::ADDR_PREFIX, vdc_pkg::UPPER_SEL, sel_s,
                       vdc_pkg::ADDR_LSB};
    end
  end

  // ==========================================================
  // Start-up sequencer
  // ==========================================================
  vdc_pkg::vdc_state_e          state_reg;
  vdc_pkg::vdc_state_e          state_next;
  logic [vdc_pkg::SS_CNT_W-1:0] ss_cnt_reg;
  logic [vdc_pkg::UV_W-1:0]     ramp_reg;
  logic                         go;
  logic                         ss_done;
  logic                         in_off;
  logic                         ramp_top;

  assign go       = en_s && sup_s;
  assign ss_done  = ss_cnt_reg >= vdc_pkg::SS_CNT_W'(SS_CYCLES - 1);
  assign in_off   = state_reg == vdc_pkg::ST_OFF;
  assign ramp_top = ramp_reg >= vdc_pkg::UV_W'(vdc_pkg::RAMP_MAX_UV);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      vdc_pkg::ST_OFF: begin
        if (go) begin
          state_next = vdc_pkg::ST_RAMP;
        end
      end
      vdc_pkg::ST_RAMP: begin
        if (!go) begin
          state_next = vdc_pkg::ST_OFF;
        end else if (ss_done) begin
          state_next = vdc_pkg::ST_RUN;
        end
      end
      vdc_pkg::ST_RUN: begin
        if (!go) begin
          state_next = vdc_pkg::ST_OFF;
        end
      end
      default: begin
        state_next = vdc_pkg::ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= vdc_pkg::ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ss_cnt_reg <= '0;
    end else if (state_reg != vdc_pkg::ST_RAMP || !go) begin
      ss_cnt_reg <= '0;
    end else if (!ss_done) begin
      ss_cnt_reg <= ss_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ramp_reg <= '0;
    end else if (in_off) begin
      ramp_reg <= '0;
    end else if (!ramp_top) begin
      ramp_reg <= ramp_reg + vdc_pkg::UV_W'(vdc_pkg::RAMP_STEP_UV);
    end
  end

  // ==========================================================
  // Reference selection and loop comparator
  // ==========================================================
  logic [vdc_pkg::UV_W-1:0] target_uv;
  logic [vdc_pkg::UV_W-1:0] ref_uv;
  logic [vdc_pkg::UV_W:0]   fb_sum;

  assign target_uv = mode_reg ? decode_uv(code_reg) : initial_level_input_i;
  assign ref_uv    = (ramp_reg < initial_level_input_i) ? ramp_reg : target_uv;
  assign fb_sum    = {1'b0, sense_uv_i} + {1'b0, ripple_uv_i};

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_uv_o <= '0;
    end else if (in_off) begin
      ref_uv_o <= '0;
    end else begin
      ref_uv_o <= ref_uv;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      one_shot_fire_o <= 1'b0;
    end else if (in_off) begin
      one_shot_fire_o <= 1'b0;
    end else begin
      one_shot_fire_o <= {1'b0, ref_uv} > fb_sum;
    end
  end

  // ==========================================================
  // Status outputs
  // ==========================================================
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      regulation_ok_output_o <= 1'b0;
    end else begin
      regulation_ok_output_o <= state_reg == vdc_pkg::ST_RUN && go;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ramp_active_o <= 1'b0;
    end else begin
      ramp_active_o <= state_reg == vdc_pkg::ST_RAMP && go;
    end
  end

  // ==========================================================
  // Enable-pin outputs
  // ==========================================================
  logic discharge_want;

  assign discharge_want = vin_s && !en_s;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      discharge_on_o <= 1'b0;
    end else begin
      discharge_on_o <= discharge_want;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      enable_pulldown_o <= 1'b0;
    end else begin
      enable_pulldown_o <= discharge_want;
    end
  end

endmodule : vdc_ctrl

`default_nettype wire

// File: sim/vdc_master.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Level and mode writer
module vdc_master (
  input  wire logic        clk_i,
  output vdc_pkg::vdc_wr_s wr_o,
  output logic             mode_wr_o,
  output logic             mode_data_o
);
  initial begin
    wr_o = '0;
    mode_wr_o = 1'b0;
    mode_data_o = 1'b0;
  end
  task put(input logic [6:0] c, input logic bad);
    wr_o = {1'b1, ~^c ^ bad, c};
    @(posedge clk_i) #1;
  endtask : put
  task idle();
    wr_o.valid = 1'b0;
  endtask : idle
  task mode(input logic v);
    mode_wr_o = 1'b1;
    mode_data_o = v;
    @(posedge clk_i) #1;
    mode_wr_o = 1'b0;
  endtask : mode
endmodule : vdc_master
`default_nettype wire

// File: sim/vdc_ctrl_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Port checker
module vdc_ctrl_chk #(
  parameter int unsigned SS_CYCLES = vdc_pkg::SS_CYC
) (
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 enable_i,
  input wire logic                 supply_ok_i,
  input wire logic                 input_present_i,
  input wire logic                 address_select_pin_i,
  input wire vdc_pkg::vdc_wr_s     level_wr_i,
  input wire logic [21:0]          sense_uv_i,
  input wire logic [21:0]          ripple_uv_i,
  input wire vdc_pkg::vdc_wr_ans_s level_ans_o,
  input wire logic [7:0]           level_reg_o,
  input wire logic                 mode_o,
  input wire logic [7:0]           slave_addr_o,
  input wire logic [21:0]          ref_uv_o,
  input wire logic                 ramp_active_o,
  input wire logic                 regulation_ok_output_o,
  input wire logic                 discharge_on_o,
  input wire logic                 enable_pulldown_o,
  input wire logic                 one_shot_fire_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [31:0] run_cnt_reg;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) run_cnt_reg <= '0;
    else run_cnt_reg <= (enable_i && supply_ok_i) ? run_cnt_reg + 32'd1 : '0;
  end
  a_good_ack: assert property (
    level_wr_i.valid && ^level_wr_i.data |=> level_ans_o.ack && !level_ans_o.nack)
    else $error("good write not acked");
  a_bad_nack: assert property (
    level_wr_i.valid && !(^level_wr_i.data) |=> level_ans_o.nack && !level_ans_o.ack)
    else $error("bad write not refused");
  a_addr_map: assert property (
    $stable(address_select_pin_i) [*5] |-> slave_addr_o == {6'h1a, address_select_pin_i, 1'b0})
    else $error("address byte wrong");
  a_discharge_ctl: assert property (
    ($stable(enable_i) && $stable(input_present_i)) [*5] |->
    (discharge_on_o == (input_present_i && !enable_i)) && (enable_pulldown_o == discharge_on_o))
    else $error("discharge path wrong");
  a_regok_early: assert property (
    $rose(regulation_ok_output_o) |-> run_cnt_reg >= SS_CYCLES)
    else $error("power good too early");
  a_regok_late: assert property (
    run_cnt_reg == SS_CYCLES + 10 |-> regulation_ok_output_o)
    else $error("power good too late");
  a_off_quiet: assert property (
    !enable_i [*6] |-> !regulation_ok_output_o && !ramp_active_o && ref_uv_o == 22'h0)
    else $error("active while disabled");
  a_fire_cmp: assert property (
    ($stable(ref_uv_o) && $stable(sense_uv_i) && $stable(ripple_uv_i)) [*3] |->
    one_shot_fire_o == ({1'b0, ref_uv_o} > {1'b0, sense_uv_i} + {1'b0, ripple_uv_i}))
    else $error("one-shot trigger wrong");
  a_target_code: assert property (
    (regulation_ok_output_o && mode_o && $stable(mode_o) && $stable(level_reg_o)) [*4] |->
    ref_uv_o == vdc_pkg::BASE_UV + {level_reg_o[6], level_reg_o[4:0]} * vdc_pkg::STEP_UV)
    else $error("decoded target wrong");
  c_ack: cover property (level_ans_o.ack);
  c_nack: cover property (level_ans_o.nack);
  c_regok_rise: cover property ($rose(regulation_ok_output_o));
endmodule : vdc_ctrl_chk
bind vdc_ctrl vdc_ctrl_chk #(.SS_CYCLES(SS_CYCLES)) chk_i (.clk_i, .rst_i, .enable_i,
  .supply_ok_i, .input_present_i, .address_select_pin_i, .level_wr_i, .sense_uv_i,
  .ripple_uv_i, .level_ans_o, .level_reg_o, .mode_o, .slave_addr_o, .ref_uv_o,
  .ramp_active_o, .regulation_ok_output_o, .discharge_on_o, .enable_pulldown_o,
  .one_shot_fire_o);
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Self-checking bench
module testbench;
  localparam int unsigned SS = 20;
  logic clk_i = 1'b0, rst_i = 1'b1, mode_wr_i, mode_data_i, mode_o, ramp_active_o;
  logic enable_i = 1'b0, supply_ok_i = 1'b0, input_present_i = 1'b0;
  logic address_select_pin_i = 1'b0, regulation_ok_output_o, one_shot_fire_o;
  logic discharge_on_o, enable_pulldown_o, reg_due = 1'b0;
  logic [21:0] initial_level_input_i = 22'h000064, sense_uv_i = '0, ripple_uv_i = '0;
  logic [21:0] ref_uv_o;
  logic [7:0] level_reg_o, slave_addr_o, exp_reg, tb_reg = 8'h32;
  logic [9:0] q[$];
  logic [9:0] e;
  logic [21:0] exp_uv [4] = '{22'h0aae60, 22'h0e2126, 22'h0e3da0, 22'h11b066};
  vdc_pkg::vdc_wr_s level_wr_i;
  vdc_pkg::vdc_wr_ans_s level_ans_o;
  int bad_count = 0, checks_done = 0, seed = 22625, cycles = 0, n;
  vdc_ctrl #(.SS_CYCLES(SS)) uut (.clk_i, .rst_i, .enable_i, .supply_ok_i,
    .input_present_i, .address_select_pin_i, .level_wr_i, .mode_wr_i, .mode_data_i,
    .initial_level_input_i, .sense_uv_i, .ripple_uv_i, .level_ans_o, .level_reg_o,
    .mode_o, .slave_addr_o, .ref_uv_o, .ramp_active_o, .regulation_ok_output_o,
    .discharge_on_o, .enable_pulldown_o, .one_shot_fire_o);
  vdc_master m (.clk_i, .wr_o(level_wr_i), .mode_wr_o(mode_wr_i), .mode_data_o(mode_data_i));
  always #25 clk_i = ~clk_i;
  task chk(input logic [21:0] got, input logic [21:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task final_report();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : cyc
  task wr(input logic [6:0] c, input logic bad);
    if (!bad) tb_reg = {~^c, c};
    q.push_back({bad ? 2'b01 : 2'b10, tb_reg});
    m.put(c, bad);
  endtask : wr
  task meas();
    n = 0;
    while (regulation_ok_output_o !== 1'b1 && n < 200) begin
      if (n == 8) chk(ref_uv_o, 22'(4 * vdc_pkg::RAMP_STEP_UV));
      if (n == SS / 2) chk(ramp_active_o, 1'b1);
      cyc(1);
      n++;
    end
    chk(ramp_active_o, 1'b0);
    chk(22'(n >= SS && n <= SS + 10), 22'h1);
  endtask : meas
  always @(posedge clk_i) begin
    #2;
    if (reg_due) chk(level_reg_o, exp_reg);
    reg_due = 1'b0;
    if (level_ans_o.ack || level_ans_o.nack) begin
      e = (q.size() > 0) ? q.pop_front() : 10'h3ff;
      chk(level_ans_o, e[9:8]);
      exp_reg = e[7:0];
      reg_due = 1'b1;
    end
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      $display("ERROR %0t timeout", $time);
      final_report();
    end
  end
  initial begin
    repeat (3) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    chk(level_reg_o, 8'h32);
    chk(mode_o, 1'b0);
    chk(slave_addr_o, 8'h68);
    address_select_pin_i = 1'b1;
    input_present_i = 1'b1;
    cyc(5);
    chk(slave_addr_o, 8'h6a);
    chk({discharge_on_o, enable_pulldown_o}, 2'b11);
    enable_i = 1'b1;
    cyc(40);
    chk({regulation_ok_output_o, discharge_on_o}, 2'b00);
    supply_ok_i = 1'b1;
    meas();
    enable_i = 1'b0;
    cyc(6);
    chk({regulation_ok_output_o, discharge_on_o}, 2'b01);
    enable_i = 1'b1;
    cyc(10);
    enable_i = 1'b0;
    cyc(3);
    enable_i = 1'b1;
    meas();
    cyc(3);
    chk(ref_uv_o, initial_level_input_i);
    for (int i = 0; i < 12; i++) wr(7'($random(seed)), 1'($random(seed)));
    m.idle();
    m.mode(1'b1);
    cyc(3);
    chk(mode_o, 1'b1);
    for (int i = 0; i < 8; i++) begin
      wr({i[2], i[1], {5{i[0]}}}, 1'b0);
      m.idle();
      cyc(5);
      chk(ref_uv_o, exp_uv[{i[2], i[0]}]);
      ripple_uv_i = 22'($random(seed)) & 22'h0003ff;
      sense_uv_i = exp_uv[{i[2], i[0]}] - ripple_uv_i - 22'h1;
      cyc(4);
      chk(one_shot_fire_o, 1'b1);
      sense_uv_i = sense_uv_i + 22'h1;
      cyc(4);
      chk(one_shot_fire_o, 1'b0);
    end
    m.mode(1'b0);
    cyc(4);
    chk(ref_uv_o, initial_level_input_i);
    enable_i = 1'b0;
    cyc(6);
    chk(ref_uv_o, 22'h0);
    rst_i = 1'b1;
    cyc(2);
    rst_i = 1'b0;
    chk(level_reg_o, 8'h32);
    cyc(5);
    chk(slave_addr_o, 8'h6a);
    final_report();
  end
endmodule : testbench
`default_nettype wire
